//--- design/office_ctrl_consts.svh
`ifndef OFFICE_CTRL_CONSTS_SVH
`define OFFICE_CTRL_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL    8'h00
`define OFS_CAP     8'h04
`define OFS_MSREQ   8'h08
`define OFS_CONSTELLATION_ASSIGN_CMD 8'h0c
`define OFS_STATUS  8'h10
// Control and capability field positions
`define CTRL_START  0
`define CTRL_PM     1
`define CAP_UP      0
`define CAP_DN      1
`define CAP_PSD     2
`define CAP_PTM     3
`define CAP_ATM     4
`define CAP_OAM     5
`define CAP_DF      6
// Reset values
`define CAP_RST     7'h40
`define CONSTELLATION_ASSIGN_CMD_RST 8'h40
// First-step constellation points
`define STEP1_CONSTELLATION_ASSIGN_CMD 8'h04
// Office trigger hold time and clock rate
`define TRIG_MS     50
`define CLK_KHZ     100000
`define TRIG_CYC    (`TRIG_MS * `CLK_KHZ)
`endif

//--- design/office_ctrl_pkg.sv
package office_ctrl_pkg;
  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_WAIT_DF = 9'h002,
    ST_CHG     = 9'h004,
    ST_ACK     = 9'h008,
    ST_RTRIG   = 9'h010,
    ST_HOLD    = 9'h020,
    ST_SS      = 9'h040,
    ST_CONST   = 9'h080,
    ST_DONE    = 9'h100
  } seq_e;
  typedef enum logic [1:0] {
    MSG_NONE = 2'h0,
    MSG_CHG  = 2'h1,
    MSG_CST  = 2'h2,
    MSG_PM   = 2'h3
  } msg_e;
  // One capability or mode-select bit group
  typedef struct packed {
    logic df;
    logic oam;
    logic atm;
    logic ptm;
    logic psd;
    logic dn;
    logic up;
  } caps_s;
  // Overhead message toward the remote end
  typedef struct packed {
    logic       valid;
    msg_e       code;
    logic [7:0] constellation_assign_cmd;
  } msg_s;
endpackage : office_ctrl_pkg

//--- design/office_link_ctrl.sv
// Contract
// - Optional two-step activation, 4-point first; the sequencer always runs both steps
// - First reach steady state on default set
// - Step-one profile uses constellation four
// - Change command loads step-one profile
// - Assign original size, change again
// - Monitoring messages allowed between steps
// - Capability list sets annex bit, level-3 fields
// - Advertise optional bands, spectrum reduction
// - Advertise packet, cell, clear OAM
// - Default-set bit means use listed set
// - Mode select sets one band bit
// - Transport bits need both messages set
`include "office_ctrl_consts.svh"
module office_link_ctrl
  import office_ctrl_pkg::*;
#(
  parameter int TRIG_CYC = `TRIG_CYC
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // Link toward the remote transceiver
  input  wire logic                  rx_remote_trig,
  input  wire logic                  rx_msg_ack,
  input  wire logic                  rx_steady,
  input  wire logic                  rx_req_valid,
  input  wire office_ctrl_pkg::caps_s rx_req_caps,
  output office_ctrl_pkg::msg_s      tx_msg,
  output logic                       tx_office_trig,
  output office_ctrl_pkg::caps_s     tx_list_caps,
  output logic                       tx_list_level3,
  output office_ctrl_pkg::caps_s     tx_mode_caps
);
  import office_ctrl_pkg::*;

  localparam logic [22:0] HOLD_LAST = 23'(TRIG_CYC - 1);

  typedef struct packed {
    seq_e        seq;
    logic        step2;
    logic [22:0] cnt;
    logic        pm_pend;
    caps_s       cap;
    caps_s       msreq;
    caps_s       req;
    logic [7:0]  constellation_assign_cmd;
    msg_s        msg;
    logic        otrig;
    caps_s       list;
    logic        lvl3;
    caps_s       mode;
    logic [31:0] rdata;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic        vld_d;
  } state_s;

  state_s st;
  state_s next_st;

  // Synchronised link levels: trig, ack, steady, request valid
  logic sy_trig;
  logic sy_ack;
  logic sy_steady;
  logic sy_vld;
  assign sy_trig   = st.s2[0];
  assign sy_ack    = st.s2[1];
  assign sy_steady = st.s2[2];
  assign sy_vld    = st.s2[3];

  // Bits offered in our capability list message
  function automatic caps_s list_of(caps_s c);
    caps_s r;
    r = c;
    if (c == '0) begin
      r.df = 1'b1; // Never advertise an empty annex field
    end
    return r;
  endfunction : list_of

  always_comb begin
    caps_s lst;
    next_st = st;
    lst = list_of(st.cap);
    next_st.msg.valid = 1'b0;
    next_st.rdata     = 32'h0;
    // Two-flop sync of the link inputs, second stage only is read
    next_st.s1    = {rx_req_valid, rx_steady, rx_msg_ack, rx_remote_trig};
    next_st.s2    = st.s1;
    next_st.vld_d = sy_vld;
    // Latch the last request message on its valid edge
    if (sy_vld && !st.vld_d) begin
      next_st.req = rx_req_caps; // Bits held stable while valid stands
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `OFS_CTRL: begin
          if (reg_wdata[`CTRL_START] && (st.seq == ST_IDLE || st.seq == ST_DONE)) begin
            next_st.seq   = ST_WAIT_DF;
            next_st.step2 = 1'b0;
          end
          if (reg_wdata[`CTRL_PM]) begin
            next_st.pm_pend = 1'b1;
          end
        end
        `OFS_CAP:     next_st.cap     = caps_s'(reg_wdata[6:0]);
        `OFS_MSREQ:   next_st.msreq   = caps_s'(reg_wdata[6:0]);
        `OFS_CONSTELLATION_ASSIGN_CMD: next_st.constellation_assign_cmd = reg_wdata[7:0];
        default: begin
        end
      endcase
    end
    // Register reads, data valid the next cycle
    if (reg_rd) begin
      case (reg_addr)
        `OFS_CAP:     next_st.rdata = {25'h0, st.cap};
        `OFS_MSREQ:   next_st.rdata = {25'h0, st.msreq};
        `OFS_CONSTELLATION_ASSIGN_CMD: next_st.rdata = {24'h0, st.constellation_assign_cmd};
        `OFS_STATUS:  next_st.rdata = {14'h0, st.req, st.pm_pend, st.step2, st.seq};
        default:      next_st.rdata = 32'h0;
      endcase
    end
    next_st.list = lst;
    next_st.lvl3 = lst.df;
    next_st.mode.df = lst.df;
    next_st.mode.up  = st.msreq.up;
    next_st.mode.dn  = st.msreq.dn & ~st.msreq.up;
    next_st.mode.psd = st.msreq.psd;
    next_st.mode.ptm = lst.ptm & st.req.ptm;
    next_st.mode.atm = lst.atm & st.req.atm;
    next_st.mode.oam = lst.oam & st.req.oam;
    // Two-step activation sequencer
    // two-step sequence
    case (st.seq)
      ST_IDLE: begin
      end
      ST_WAIT_DF: begin
        if (sy_steady) begin
          next_st.seq = ST_CHG;
        end
      end
      ST_CHG: begin
        next_st.msg.valid = 1'b1;
        next_st.msg.code  = MSG_CHG;
        next_st.msg.constellation_assign_cmd = st.step2 ? st.constellation_assign_cmd : `STEP1_CONSTELLATION_ASSIGN_CMD;
        next_st.seq = ST_ACK;
      end
      ST_ACK: begin
        if (sy_ack) begin
          next_st.seq = ST_RTRIG;
        end
      end
      ST_RTRIG: begin
        if (sy_trig) begin
          next_st.seq = ST_HOLD;
          next_st.cnt = '0;
        end
      end
      ST_HOLD: begin
        next_st.cnt = st.cnt + 23'h1;
        if (st.cnt == HOLD_LAST) begin
          next_st.seq = ST_SS;
        end
      end
      ST_SS: begin
        if (sy_steady) begin
          next_st.seq = st.step2 ? ST_DONE : ST_CONST;
        end
      end
      ST_CONST: begin
        next_st.msg.valid   = 1'b1;
        next_st.msg.code    = MSG_CST;
        next_st.msg.constellation_assign_cmd = st.constellation_assign_cmd;
        next_st.step2       = 1'b1;
        next_st.seq         = ST_CHG;
      end
      ST_DONE: begin
      end
      default: next_st.seq = ST_IDLE;
    endcase
    next_st.otrig = (next_st.seq == ST_HOLD);
    // monitoring message in any state but ST_CHG and ST_CONST
    if (st.pm_pend && !next_st.msg.valid && st.seq != ST_CHG && st.seq != ST_CONST) begin
      next_st.msg.valid   = 1'b1;
      next_st.msg.code    = MSG_PM;
      next_st.msg.constellation_assign_cmd = 8'h00;
      next_st.pm_pend     = reg_wr && reg_addr == `OFS_CTRL && reg_wdata[`CTRL_PM];
    end
  end

  // Single state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st         <= '0;
      st.seq     <= ST_IDLE;
      st.cap     <= caps_s'(`CAP_RST);
      st.constellation_assign_cmd <= `CONSTELLATION_ASSIGN_CMD_RST;
      st.list    <= caps_s'(`CAP_RST);
      st.lvl3    <= 1'b1;
      st.mode.df <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata      = st.rdata;
  assign tx_msg         = st.msg;
  assign tx_office_trig = st.otrig;
  assign tx_list_caps   = st.list;
  assign tx_list_level3 = st.lvl3;
  assign tx_mode_caps   = st.mode;

endmodule : office_link_ctrl

//--- sim/office_link_monitor.sv
module office_link_monitor
  import office_ctrl_pkg::*;
#(
  parameter int TRIG_CYC = 8
) (
  // Clock, reset and register port
  input wire logic clk_sys, srst, reg_rd,
  input wire logic [31:0] reg_rdata,
  // Link toward the remote end
  input wire logic rx_remote_trig, tx_office_trig, tx_list_level3,
  input wire msg_s tx_msg,
  input wire caps_s tx_list_caps, tx_mode_caps
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [31:0] hold_cnt;
  // Trigger age; a short or long hold shows up at the fall
  always_ff @(posedge clk_sys) begin
    if (srst || !tx_office_trig) hold_cnt <= '0;
    else hold_cnt <= hold_cnt + 32'h1;
  end
  trig_hold_a: assert property ($fell(tx_office_trig) |-> hold_cnt == TRIG_CYC)
    else $error("trigger hold too short");
  trig_max_a: assert property (tx_office_trig |-> hold_cnt < TRIG_CYC)
    else $error("trigger hold too long");
  trig_cause_a: assert property ($rose(tx_office_trig) |-> $past(rx_remote_trig, 2))
    else $error("trigger without remote trigger");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  list_annex_a: assert property (tx_list_caps != 7'h0 && tx_list_level3 == tx_list_caps.df)
    else $error("capability list malformed");
  band_one_a: assert property (!(tx_mode_caps.up && tx_mode_caps.dn))
    else $error("both optional bands selected");
  mode_sub_a: assert property ($stable(tx_list_caps) |-> (tx_mode_caps[5:3] & ~tx_list_caps[5:3]) == 3'h0)
    else $error("transport bit not offered");
  mode_df_a: assert property ($stable(tx_list_caps) |-> tx_mode_caps.df == tx_list_caps.df)
    else $error("default set bit differs");
  cover property ($rose(tx_office_trig));
  cover property (tx_msg.valid && tx_msg.code == MSG_CST);
  cover property (tx_msg.valid && tx_msg.code == MSG_PM);
endmodule : office_link_monitor

bind office_link_ctrl office_link_monitor #(.TRIG_CYC(TRIG_CYC)) i_office_link_monitor (.clk_sys, .srst,
  .reg_rd, .reg_rdata, .rx_remote_trig, .tx_office_trig, .tx_list_level3, .tx_msg, .tx_list_caps, .tx_mode_caps);

//--- sim/remote_xcvr_model.sv
module remote_xcvr_model
  import office_ctrl_pkg::*;
(
  // Clock and office side
  input wire logic clk_sys, srst, tx_office_trig, quiet, req_on,
  input wire msg_s tx_msg,
  input wire logic [3:0] lat,
  input wire caps_s req_caps,
  // Toward the controller
  output logic rx_remote_trig, rx_msg_ack, rx_steady, rx_req_valid,
  output caps_s rx_req_caps,
  output logic [7:0] cur_set
);
  localparam int TMO = 400; // Trigger timeout in cycles, arbitrary
  localparam logic [7:0] WS_SET = 8'h04;
  logic [1:0] st; // 0 power-up, 1 active, 2 trigger
  logic [7:0] new_set, prev_set;
  logic [3:0] wt;
  logic [9:0] tmo;
  logic go;
  // Lat stretches the confirm so slow remotes are exercised too
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= 2'd1; go <= 1'b0; wt <= '0; tmo <= '0;
      cur_set <= 8'h40; new_set <= 8'h40; prev_set <= 8'h40;
    end else begin
      if (tx_msg.valid && tx_msg.code != MSG_PM) new_set <= tx_msg.constellation_assign_cmd;
      if (tx_msg.valid && tx_msg.code == MSG_CHG) begin go <= 1'b1; wt <= lat; end
      if (go && st == 2'd1) begin
        if (wt != 4'h0) wt <= wt - 4'h1;
        else begin st <= 2'd2; go <= 1'b0; tmo <= '0; end
      end
      if (st == 2'd2) begin
        tmo <= tmo + 10'h1;
        if (tx_office_trig) begin cur_set <= new_set; prev_set <= new_set; st <= 2'd1; end
        else if (tmo == TMO || quiet) begin st <= 2'd0; cur_set <= WS_SET; end
      end
    end
  end
  // trigger bit only in trigger state
  assign rx_remote_trig = (st == 2'd2);
  assign rx_msg_ack = (st == 2'd2);
  assign rx_steady = (st == 2'd1) && !go;
  assign rx_req_valid = req_on;
  assign rx_req_caps = caps_s'(req_caps | 7'h40);
endmodule : remote_xcvr_model

//--- sim/tb_office_link_ctrl.sv
`include "office_ctrl_consts.svh"
module tb_office_link_ctrl import office_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic clk_sys, srst, reg_wr, reg_rd, quiet, req_on, rx_remote_trig, rx_msg_ack, rx_steady;
  logic rx_req_valid, tx_office_trig, tx_list_level3;
  logic [7:0] reg_addr, cur_set;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0] lat;
  caps_s req_caps, rx_req_caps, tx_list_caps, tx_mode_caps;
  msg_s tx_msg;
  logic [9:0] q[$];
  int error_cnt, check_count;
  row_s rows [5] = '{'{1'b0, `OFS_CAP, 32'h0, 32'h40}, '{1'b0, `OFS_CONSTELLATION_ASSIGN_CMD, 32'h0, 32'h40},
    '{1'b1, `OFS_MSREQ, 32'h7, 32'h7}, '{1'b1, 8'h20, 32'h5, 32'h0}, '{1'b1, `OFS_CAP, 32'h7f, 32'h7f}};
  logic [9:0] exp_m [4] = '{10'h104, 10'h300, 10'h210, 10'h110};
  office_link_ctrl #(.TRIG_CYC(8)) i_office_link_ctrl (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rx_remote_trig, .rx_msg_ack, .rx_steady, .rx_req_valid, .rx_req_caps, .tx_msg,
    .tx_office_trig, .tx_list_caps, .tx_list_level3, .tx_mode_caps);
  remote_xcvr_model i_remote_xcvr_model (.clk_sys, .srst, .tx_office_trig, .quiet, .req_on, .tx_msg, .lat,
    .req_caps, .rx_remote_trig, .rx_msg_ack, .rx_steady, .rx_req_valid, .rx_req_caps, .cur_set);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Log every message pulse toward the remote end
  always @(posedge clk_sys) if (tx_msg.valid) q.push_back({tx_msg.code, tx_msg.constellation_assign_cmd});
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task pause(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : pause
  task wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    pause(1);
  endtask : wr
  task rd(input logic [7:0] a);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Hang guard, far beyond the roughly 90 cycles needed
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {reg_wr, reg_rd, quiet, req_on} = '0;
    srst = 1'b1; reg_addr = '0; reg_wdata = '0; lat = 4'h6; req_caps = 7'h28;
    pause(4);
    srst <= 1'b0;
    pause(1);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("reg", d, rows[i].e);
    end
    $display("register rows done");
    req_on <= 1'b1;
    pause(8);
    chk("mode", tx_mode_caps, 7'h6d);
    wr(`OFS_CAP, 32'h0);
    pause(3);
    chk("list", {tx_list_level3, tx_list_caps}, 8'hc0);
    chk("mode0", tx_mode_caps[6:3], 4'h8);
    $display("capability tests done");
    wr(`OFS_CONSTELLATION_ASSIGN_CMD, 32'h10);
    wr(`OFS_CTRL, 32'h1);
    for (int n = 0; n < 100 && q.size() == 0; n++) pause(1);
    wr(`OFS_CTRL, 32'h2);
    for (int n = 0; n < 300 && d[8:0] !== 9'h100; n++) rd(`OFS_STATUS);
    chk("done", d[8:0], 9'h100);
    chk("count", q.size(), 4);
    foreach (exp_m[i]) chk("msg", (q[i][9:8] == 2'h3) ? {q[i][9:8], 8'h0} : q[i], exp_m[i]);
    chk("set", cur_set, 8'h10);
    $display("two-step bring-up done");
    lat <= 4'h0;
    wr(`OFS_CTRL, 32'h1);
    pause(4);
    srst <= 1'b1;
    pause(4);
    srst <= 1'b0;
    pause(1);
    rd(`OFS_STATUS);
    chk("reset", d[8:0], 9'h001);
    chk("trig", tx_office_trig, 1'b0);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule : tb_office_link_ctrl
